/* File: verilog/lpac_capture.sv */
// Link partner ability capture register with base-page and next-page views
`timescale 1ns/100ps
`include "lpac_map.svh"
module lpac_capture
  import lpac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire lpac_mgmt_req_t mgmt_req,
  input wire logic mgmt_wr_en,
  input wire logic [15:0] mgmt_wr_data,
  input wire lpac_page_t page_in,
  input wire logic np_supported,
  input wire logic an_complete,
  input wire logic an_restart,
  input wire logic partner_ack,
  output logic [15:0] mgmt_rd_data,
  output logic mgmt_rd_hit,
  output logic next_view
);

  lpac_state_t st;
  lpac_state_t next_st;
  logic [15:0] view_word;
  logic take_base;
  logic take_next;
  logic drop_next;

  // Capture qualifiers; a restart outranks any page in the same cycle
  assign take_base = page_in.valid && !page_in.is_next && !an_restart;
  assign take_next = page_in.valid && page_in.is_next && np_supported && an_complete
    && !an_restart;
  assign drop_next = page_in.valid && page_in.is_next && !(np_supported && an_complete)
    && !an_restart;

  // Reading view assembled field by field from the captured word and the acknowledge register
  always_comb
  begin
    view_word = 16'h0000;
    view_word[`LPAC_BIT_MORE_PAGES] = st.word[`LPAC_BIT_MORE_PAGES];
    view_word[`LPAC_BIT_ACK] = st.ack;
    if (st.next_view)
    begin
      // Next-page fields pass straight through
      view_word[`LPAC_BIT_MSG_PAGE] = st.word[`LPAC_BIT_MSG_PAGE];
      view_word[`LPAC_BIT_MSG_COMPLY] = st.word[`LPAC_BIT_MSG_COMPLY];
      view_word[`LPAC_BIT_TOGGLE] = st.word[`LPAC_BIT_TOGGLE];
      view_word[`LPAC_CODE_MSB:0] = st.word[`LPAC_CODE_MSB:0];
    end
    else
    begin
      // Base-page fields; the reserved bit never leaks a one
      view_word[`LPAC_BIT_FAR_FAULT] = st.word[`LPAC_BIT_FAR_FAULT];
      view_word[`LPAC_BIT_RSVD] = 1'b0;
      view_word[`LPAC_BIT_ONE_WAY_FLOW] = st.word[`LPAC_BIT_ONE_WAY_FLOW];
      view_word[`LPAC_BIT_PAUSE] = st.word[`LPAC_BIT_PAUSE];
      view_word[`LPAC_BIT_T4] = st.word[`LPAC_BIT_T4];
      view_word[`LPAC_BIT_FAST_FD] = st.word[`LPAC_BIT_FAST_FD];
      view_word[`LPAC_BIT_FAST] = st.word[`LPAC_BIT_FAST];
      view_word[`LPAC_BIT_SLOW_FD] = st.word[`LPAC_BIT_SLOW_FD];
      view_word[`LPAC_BIT_SLOW] = st.word[`LPAC_BIT_SLOW];
      view_word[`LPAC_SEL_MSB:0] = st.word[`LPAC_SEL_MSB:0];
    end
  end

  // Next-state logic
  always_comb
  begin
    next_st = st;
    next_st.ack = partner_ack;
    if (an_restart)
    begin
      next_st.word = `LPAC_WORD_RESET;
      next_st.next_view = 1'b0;
    end
    else if (page_in.valid && !page_in.is_next)
    begin
      next_st.word = page_in.word;
      next_st.next_view = 1'b0;
    end
    else if (page_in.valid && page_in.is_next && np_supported && an_complete)
    begin
      next_st.word = page_in.word;
      next_st.next_view = 1'b1;
    end
    // Writes never touch the word; mgmt_wr_en and mgmt_wr_data unused by design
    next_st.rd_hit = mgmt_req.rd_en && (mgmt_req.addr == `LPAC_PARTNER_WORD_ADDR);
    next_st.rd_data = next_st.rd_hit ? view_word : 16'h0000;
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign mgmt_rd_data = st.rd_data;
  assign mgmt_rd_hit = st.rd_hit;
  assign next_view = st.next_view;

  // Read handshake checks
  // A read of the partner word answers one cycle later
  read_hit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_req.rd_en && mgmt_req.addr == `LPAC_PARTNER_WORD_ADDR |=> mgmt_rd_hit)
    else $error("read of partner word not answered");

  // Data bus stays quiet outside a hit
  miss_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !mgmt_rd_hit |-> mgmt_rd_data == 16'h0000)
    else $error("data on missed read");

  // Other addresses never answer
  miss_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_req.rd_en && mgmt_req.addr != `LPAC_PARTNER_WORD_ADDR |=> !mgmt_rd_hit)
    else $error("foreign address answered");

  // No request, no answer
  idle_no_hit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !mgmt_req.rd_en |=> !mgmt_rd_hit)
    else $error("answer without request");

  // Every answer traces back to a request
  hit_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit |-> $past(mgmt_req.rd_en) && $past(mgmt_req.addr) == `LPAC_PARTNER_WORD_ADDR)
    else $error("answer has no matching request");

  // Answer carries the view of the request cycle
  hit_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit |-> mgmt_rd_data == $past(view_word))
    else $error("read data not the current view");

  // Base view field checks
  // Reserved bit always reads zero
  rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !$past(next_view) |-> !mgmt_rd_data[`LPAC_BIT_RSVD])
    else $error("reserved bit read as one");

  // More-pages request passes through
  more_pages_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !$past(next_view) |-> mgmt_rd_data[15] == $past(st.word[15]))
    else $error("base more-pages bit wrong");

  // Remote fault passes through
  far_fault_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !$past(next_view) |-> mgmt_rd_data[13] == $past(st.word[13]))
    else $error("remote fault bit wrong");

  // Asymmetric pause passes through
  one_way_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !$past(next_view) |-> mgmt_rd_data[11] == $past(st.word[11]))
    else $error("asymmetric pause bit wrong");

  // Symmetric pause passes through
  pause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !$past(next_view) |-> mgmt_rd_data[10] == $past(st.word[10]))
    else $error("pause bit wrong");

  // Four-pair capability passes through
  t4_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !$past(next_view) |-> mgmt_rd_data[9] == $past(st.word[9]))
    else $error("four-pair bit wrong");

  // Fast full duplex passes through
  fast_fd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !$past(next_view) |-> mgmt_rd_data[8] == $past(st.word[8]))
    else $error("fast full duplex bit wrong");

  // Fast half duplex passes through
  fast_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !$past(next_view) |-> mgmt_rd_data[7] == $past(st.word[7]))
    else $error("fast bit wrong");

  // Slow full duplex passes through
  slow_fd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !$past(next_view) |-> mgmt_rd_data[6] == $past(st.word[6]))
    else $error("slow full duplex bit wrong");

  // Slow half duplex passes through
  slow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !$past(next_view) |-> mgmt_rd_data[5] == $past(st.word[5]))
    else $error("slow bit wrong");

  // Selector field passes through
  selector_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !$past(next_view) |-> mgmt_rd_data[4:0] == $past(st.word[4:0]))
    else $error("selector field wrong");

  // Next view field checks
  // More-pages request in the next view
  next_more_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && $past(next_view) |-> mgmt_rd_data[15] == $past(st.word[15]))
    else $error("next more-pages bit wrong");

  // Message-page flag passes through
  msg_page_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && $past(next_view) |-> mgmt_rd_data[13] == $past(st.word[13]))
    else $error("message page flag wrong");

  // Compliance bit is not masked in the next view
  comply_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && $past(next_view) |-> mgmt_rd_data[12] == $past(st.word[12]))
    else $error("compliance bit wrong");

  // Toggle bit passes through
  toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && $past(next_view) |-> mgmt_rd_data[11] == $past(st.word[11]))
    else $error("toggle bit wrong");

  // Code field passes through
  code_field_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && $past(next_view) |-> mgmt_rd_data[10:0] == $past(st.word[10:0]))
    else $error("code field wrong");

  // Acknowledge checks
  // Read data bit 14 is the engine acknowledge of two edges back
  ack_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_req.rd_en && mgmt_req.addr == `LPAC_PARTNER_WORD_ADDR
    |=> mgmt_rd_data[14] == $past(partner_ack, 2))
    else $error("acknowledge bit not from engine");

  // Acknowledge register follows the engine every cycle
  ack_reg_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> st.ack == $past(partner_ack))
    else $error("acknowledge not registered");

  // Acknowledge also shown in the next view
  ack_next_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && $past(next_view) |-> mgmt_rd_data[14] == $past(st.ack))
    else $error("next view acknowledge wrong");

  // Capture checks
  // Base page selects the base view
  base_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take_base |=> !next_view)
    else $error("base page did not select base view");

  // Base page word is stored as received
  base_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take_base |=> st.word == $past(page_in.word))
    else $error("base page word not stored");

  // Next page after completion selects the next view
  next_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take_next |=> next_view)
    else $error("next page not captured");

  // Next page word is stored as received
  next_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take_next |=> st.word == $past(page_in.word))
    else $error("next page word not stored");

  // Next view only through a qualified next page
  no_early_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !next_view && !take_next |=> !next_view)
    else $error("next view entered early");

  // Unqualified next page leaves the word alone
  drop_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    drop_next |=> $stable(st.word))
    else $error("early next page overwrote word");

  // Unqualified next page leaves the view alone
  drop_view_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    drop_next |=> $stable(next_view))
    else $error("early next page changed view");

  // View holds while no page arrives
  view_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !page_in.valid && !an_restart |=> $stable(next_view))
    else $error("view changed without a page");

  // Word holds while no page arrives
  idle_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !page_in.valid && !an_restart |=> $stable(st.word))
    else $error("word changed without a page");

  // Restart clears the word and returns to the base view
  restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    an_restart |=> st.word == 16'h0000 && !next_view)
    else $error("restart did not clear word");

  // Write checks
  // Writes never change the captured word
  wr_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_wr_en && !page_in.valid && !an_restart |=> $stable(st.word))
    else $error("write changed captured word");

  // Writes never change the view
  wr_view_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_wr_en && !page_in.valid && !an_restart |=> $stable(next_view))
    else $error("write changed view");

  // Reset checks
  // First edge after release still shows the reset state
  after_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(rst_n) |-> !mgmt_rd_hit && mgmt_rd_data == 16'h0000 && !next_view)
    else $error("outputs not cleared by reset");

  // Main scenarios
  base_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && !next_view && mgmt_rd_data[7]);
  next_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && next_view);
  ack_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_rd_hit && mgmt_rd_data[14]);
  drop_next_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    drop_next);
  restart_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    an_restart && next_view);

endmodule // lpac_capture

/* File: verilog/lpac_map.svh */
// Register offsets, field positions and reset values of the partner ability capture
`ifndef LPAC_MAP_SVH
`define LPAC_MAP_SVH
`define LPAC_PARTNER_WORD_ADDR 5'h05
`define LPAC_BIT_MORE_PAGES 15
`define LPAC_BIT_ACK 14
`define LPAC_BIT_FAR_FAULT 13
`define LPAC_BIT_RSVD 12
`define LPAC_BIT_ONE_WAY_FLOW 11
`define LPAC_BIT_PAUSE 10
`define LPAC_BIT_T4 9
`define LPAC_BIT_FAST_FD 8
`define LPAC_BIT_FAST 7
`define LPAC_BIT_SLOW_FD 6
`define LPAC_BIT_SLOW 5
`define LPAC_SEL_MSB 4
`define LPAC_BIT_MSG_PAGE 13
`define LPAC_BIT_MSG_COMPLY 12
`define LPAC_BIT_TOGGLE 11
`define LPAC_CODE_MSB 10
`define LPAC_WORD_RESET 16'h0000
`define LPAC_BASE_RSVD_MASK 16'hEFFF
`endif

/* File: verilog/lpac_pkg.sv */
// Types shared by the partner ability capture block
package lpac_pkg;
  // Management read request
  typedef struct packed {
    logic rd_en;
    logic [4:0] addr;
  } lpac_mgmt_req_t;
  // Page captured by the negotiation engine
  typedef struct packed {
    logic valid;
    logic is_next;
    logic [15:0] word;
  } lpac_page_t;
  // Whole module state
  typedef struct packed {
    logic [15:0] word;
    logic next_view;
    logic ack;
    logic [15:0] rd_data;
    logic rd_hit;
  } lpac_state_t;
endpackage

/* File: dv/lpac_partner.sv */
// Remote partner model delivering received pages and acknowledge
`timescale 1ns/100ps
module lpac_partner
  import lpac_pkg::*;
(
  input wire logic clk_sys,
  output lpac_page_t page_out,
  output logic ack_out
);
  initial page_out = '0;
  initial ack_out = 1'b0;
  // One page pulse; the word is scrambled once released
  task automatic send(input logic nxt, input logic [15:0] w, input logic ack);
    @(posedge clk_sys);
    page_out <= '{1'b1, nxt, w};
    ack_out <= ack;
    @(posedge clk_sys);
    page_out <= '{1'b0, 1'b0, ~w};
  endtask
endmodule // lpac_partner

/* File: dv/lpac_capture_tb.sv */
// Self-checking bench for the partner ability capture register
`timescale 1ns/100ps
module lpac_capture_tb;
  import lpac_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  lpac_mgmt_req_t req = '0;
  logic wr_en = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic np_ok = 1'b0;
  logic an_done = 1'b0;
  logic restart = 1'b0;
  lpac_page_t page;
  logic ack;
  logic [15:0] rd_data;
  logic hit;
  logic view;
  int failures = 0;
  int num_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  lpac_capture dut (.clk_sys(clk_sys), .rst_n(rst_n), .mgmt_req(req), .mgmt_wr_en(wr_en),
    .mgmt_wr_data(wr_data), .page_in(page), .np_supported(np_ok), .an_complete(an_done),
    .an_restart(restart), .partner_ack(ack), .mgmt_rd_data(rd_data), .mgmt_rd_hit(hit),
    .next_view(view));
  lpac_partner far_end (.clk_sys(clk_sys), .page_out(page), .ack_out(ack));
  // Compare one value against its expectation
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Read one address; compare hit, view and data together
  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic h, input logic v);
    @(posedge clk_sys);
    req <= '{1'b1, a};
    @(posedge clk_sys);
    req <= '0;
    #1;
    check("rd", {hit, view, rd_data}, {h, v, exp});
  endtask
  task automatic give_verdict();
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Pages, writes, unmapped reads, next pages and restart
  task automatic t_base();
    rd(5'h05, 16'h0000, 1'b1, 1'b0);
    far_end.send(1'b0, 16'hFFFF, 1'b1);
    rd(5'h05, 16'hEFFF, 1'b1, 1'b0);
    far_end.send(1'b0, 16'h2DE1, 1'b0);
    rd(5'h05, 16'h2DE1, 1'b1, 1'b0);
  endtask
  task automatic t_write();
    @(posedge clk_sys);
    wr_en <= 1'b1;
    wr_data <= 16'hAFFF; // Reserved and acknowledge bits written as 0
    @(posedge clk_sys);
    wr_en <= 1'b0;
    rd(5'h05, 16'h2DE1, 1'b1, 1'b0);
    rd(5'h06, 16'h0000, 1'b0, 1'b0);
  endtask
  task automatic t_next();
    far_end.send(1'b1, 16'hBABC, 1'b0);
    rd(5'h05, 16'h2DE1, 1'b1, 1'b0);
    @(posedge clk_sys);
    np_ok <= 1'b1;
    an_done <= 1'b1;
    far_end.send(1'b1, 16'hBABC, 1'b0);
    rd(5'h05, 16'hBABC, 1'b1, 1'b1);
    @(posedge clk_sys);
    restart <= 1'b1;
    @(posedge clk_sys);
    restart <= 1'b0;
    rd(5'h05, 16'h0000, 1'b1, 1'b0);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_base();
    t_write();
    t_next();
    give_verdict();
  end
  // Watchdog
  initial
  begin
    #50000;
    failures++;
    give_verdict();
  end
endmodule // lpac_capture_tb
